// file: cmc_bus_node.sv
// Partner: a remote node on the wired-AND bus behind the transceiver.
// Assumes the bench calls drive_dominant right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_node
(
   // Clock
   input wire logic pclk,
   // Controller pins
   input wire logic bus_transmit_pin,
   output logic bus_receive_pin
);
   logic node_low = 1'b0;
   // Recessive unless some node pulls the bus low
   assign bus_receive_pin = bus_transmit_pin & ~node_low;
   // Dominant for n clock cycles, then released to recessive
   task automatic drive_dominant(input int n);
      node_low <= 1'b1;
      repeat (n) @(posedge pclk);
      node_low <= 1'b0;
   endtask : drive_dominant
endmodule : cmc_bus_node
`default_nettype wire

// file: cmc_chk.sv
// Checker: port relations of the CAN mode-configuration block.
// Assumes it is bound to cmc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cmc_chk
import cmc_pkg::*;
#(
   parameter logic [15:0] WAKE_CYCLES = 16'd20
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Bus pin and engine
   input wire logic bus_transmit_pin,
   input wire logic eng_tx_bit,
   input wire logic eng_tx_request,
   input wire logic eng_enable,
   input wire logic eng_run,
   input wire logic eng_rx_bit,
   input wire logic eng_ack_ignore,
   input wire logic eng_tx_grant,
   input wire logic proto_clk_sel,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed write to mode control one
   logic wr1;
   assign wr1 = psel && penable && pready && pwrite && paddr == OFS_CTL1;
   loop_pin_a: assert property (eng_ack_ignore |-> bus_transmit_pin)
      else $error("tx pin not recessive in loopback");
   loop_rx_a: assert property (eng_ack_ignore |-> eng_rx_bit == $past(eng_tx_bit))
      else $error("receiver not fed from transmitter");
   idle_pin_a: assert property (!eng_run && !$past(eng_run) |-> bus_transmit_pin)
      else $error("tx pin driven outside run");
   run_en_a: assert property (eng_run |-> eng_enable)
      else $error("running while disabled");
   off_stop_a: assert property ($fell(eng_enable) |-> ##[0:2] !eng_run)
      else $error("run kept after disable");
   tx_grant_a: assert property (eng_tx_grant |-> eng_run && $past(eng_tx_request))
      else $error("grant without request in run");
   clk_wr_a: assert property ($changed(proto_clk_sel) |-> $past(wr1) || $past(wr1, 2))
      else $error("clock select moved without write");
   loop_wr_a: assert property ($changed(eng_ack_ignore) |-> $past(wr1) || $past(wr1, 2))
      else $error("loopback moved without write");
   en_wr_a: assert property ($changed(eng_enable) |-> $past(wr1) || $past(wr1, 2))
      else $error("enable moved without write");
   // Main scenarios reached
   loop_run_c: cover property (eng_ack_ignore && eng_run);
   grant_c: cover property (eng_tx_grant);
   irq_c: cover property (irq);
endmodule : cmc_chk
bind cmc_top cmc_chk #(.WAKE_CYCLES(WAKE_CYCLES)) chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .bus_transmit_pin(bus_transmit_pin), .eng_tx_bit(eng_tx_bit),
   .eng_tx_request(eng_tx_request), .eng_enable(eng_enable), .eng_run(eng_run),
   .eng_rx_bit(eng_rx_bit), .eng_ack_ignore(eng_ack_ignore), .eng_tx_grant(eng_tx_grant),
   .proto_clk_sel(proto_clk_sel), .irq(irq));
`default_nettype wire

// file: cmc_pkg.sv
// Constants, field layout and types of the CAN mode-configuration block.
// Assumes a 200 MHz APB clock and a byte-addressed 32-bit APB register window.
package cmc_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTL1 = 8'h00;
   localparam logic [7:0] OFS_CTL0 = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0c;
   localparam logic [7:0] OFS_ERRCNT = 8'h10;

   // Mode control one field positions
   localparam int unsigned CTL1_ENABLE = 7;
   localparam int unsigned CTL1_CLKSEL = 6;
   localparam int unsigned CTL1_LOOPBACK = 5;
   localparam int unsigned CTL1_LISTEN = 4;
   localparam int unsigned CTL1_WAKEFILT = 2;
   localparam logic [7:0] CTL1_RESET = 8'h00;

   // Mode control zero field positions
   localparam int unsigned CTL0_INITREQ = 0;
   localparam int unsigned CTL0_SLEEPREQ = 1;
   localparam int unsigned CTL0_WAKEEN = 2;
   localparam int unsigned CTL0_SLEEPACK = 3;
   localparam int unsigned CTL0_INITACK = 4;
   localparam logic [2:0] CTL0_RESET = 3'h1;

   // Event bits of status and mask
   localparam int unsigned EV_TXDONE = 0;
   localparam int unsigned EV_RXDONE = 1;
   localparam int unsigned EV_WAKE = 2;
   localparam int unsigned EV_N = 3;
   localparam logic [EV_N-1:0] EV_RESET = 3'h0;

   // Error counter layout in its register
   localparam int unsigned ERR_TX_LSB = 0;
   localparam int unsigned ERR_RX_LSB = 8;
   localparam logic [7:0] ERR_MAX = 8'hff;
   localparam logic [7:0] ERR_RESET = 8'h00;

   // Bus levels
   localparam logic BIT_RECESSIVE = 1'b1;
   localparam logic BIT_DOMINANT = 1'b0;

   // Timing: clock rate and filtered wake-up minimum pulse
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned WAKE_MIN_NS = 100;
   localparam int unsigned WAKE_MIN_CYC = (WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WAKE_CNT_W = 16;

   // Controller operating state
   typedef enum logic [1:0]
   {
      ST_OFF = 2'b00,
      ST_INIT = 2'b01,
      ST_RUN = 2'b10,
      ST_SLEEP = 2'b11
   } cmc_state_t;

endpackage : cmc_pkg

// file: cmc_top.sv
// Mode-configuration logic of a CAN controller with an APB register window.
// Assumes a frame engine beside it on pclk and a transceiver on the bus pins.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Enable bit turns controller on or off
// - Clock select: oscillator or bus clock
// - Loopback feeds transmit stream into receiver
// - Loopback ignores receive pin, transmit pin recessive
// - Loopback receives own frame, ignores ack
// - Loopback still raises transmit and receive events
// - Listen mode: receive, never drive ack/error
// - Listen mode freezes both error counters
// - Listen mode blocks transmission until cleared
// - Unfiltered wake on any dominant level
// - Filtered wake needs minimum dominant pulse
// - Enable writable once, unless special mode
module cmc_top
#(
   parameter logic [15:0] WAKE_CYCLES = 16'(cmc_pkg::WAKE_MIN_CYC)
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // System mode
   input wire logic special_mode,
   // CAN bus pins
   input wire logic bus_receive_pin,
   output logic bus_transmit_pin,
   // Frame engine, inputs
   input wire logic eng_tx_bit,
   input wire logic eng_ack_or_error,
   input wire logic eng_tx_request,
   input wire logic eng_tx_done,
   input wire logic eng_rx_done,
   input wire logic eng_tx_err_inc,
   input wire logic eng_tx_err_dec,
   input wire logic eng_rx_err_inc,
   input wire logic eng_rx_err_dec,
   // Frame engine, outputs
   output logic eng_enable,
   output logic eng_run,
   output logic eng_rx_bit,
   output logic eng_ack_ignore,
   output logic eng_tx_grant,
   output logic proto_clk_sel,
   // Interrupt
   output logic irq
);
   import cmc_pkg::*;

   cmc_wake_if wif ();

   // Register state
   logic [7:0] can_mode_control_one;
   logic init_request_bit;
   logic sleep_request_bit;
   logic wakeup_enable_bit;
   logic init_acknowledge_bit;
   logic sleep_ack;
   logic enable_locked;
   logic [EV_N-1:0] status;
   logic [EV_N-1:0] mask;
   logic [7:0] tx_err_cnt;
   logic [7:0] rx_err_cnt;
   cmc_state_t state;
   cmc_state_t next_state;

   // Pin synchroniser
   logic rx_meta;
   logic rx_sync;

   // Mode decode
   logic enabled;
   logic loopback;
   logic listen;
   logic [EV_N-1:0] ev_set;
   logic [EV_N-1:0] ev_clr;

   // APB phases and hits
   logic apb_setup;
   logic apb_access;
   logic wr_ctl1;
   logic wr_ctl0;
   logic wr_mask;
   logic rd_status;
   logic ctl1_open;

   // Matches a word-aligned register offset
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   // Any mapped register
   function automatic logic mapped(input logic [7:0] addr);
      mapped = hit(addr, OFS_CTL1) || hit(addr, OFS_CTL0) || hit(addr, OFS_STATUS)
         || hit(addr, OFS_MASK) || hit(addr, OFS_ERRCNT);
   endfunction : mapped

   assign enabled = can_mode_control_one[CTL1_ENABLE];
   assign loopback = can_mode_control_one[CTL1_LOOPBACK];
   assign listen = can_mode_control_one[CTL1_LISTEN];

   // The receive pin is asynchronous; only the second stage is read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_meta <= BIT_RECESSIVE;
         rx_sync <= BIT_RECESSIVE;
      end
      else
      begin
         rx_meta <= bus_receive_pin;
         rx_sync <= rx_meta;
      end
   end

   // APB: one wait-free access cycle, pready comes from a flop set in setup
   assign apb_setup = psel && !penable;
   assign apb_access = psel && penable && pready;
   assign ctl1_open = init_request_bit && init_acknowledge_bit;
   assign wr_ctl1 = apb_access && pwrite && hit(paddr, OFS_CTL1) && ctl1_open;
   assign wr_ctl0 = apb_access && pwrite && hit(paddr, OFS_CTL0);
   assign wr_mask = apb_access && pwrite && hit(paddr, OFS_MASK);
   assign rd_status = apb_access && !pwrite && hit(paddr, OFS_STATUS);

   // Bus answer; read data is captured in setup, so a read-clear only drops what was seen
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= apb_setup;
         pslverr <= apb_setup && !mapped(paddr);
         if (apb_setup && !pwrite)
         begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, OFS_CTL1))
               prdata[7:0] <= can_mode_control_one;
            if (hit(paddr, OFS_CTL0))
               prdata[4:0] <= {init_acknowledge_bit, sleep_ack, wakeup_enable_bit,
                  sleep_request_bit, init_request_bit};
            if (hit(paddr, OFS_STATUS))
               prdata[EV_N-1:0] <= status;
            if (hit(paddr, OFS_MASK))
               prdata[EV_N-1:0] <= mask;
            if (hit(paddr, OFS_ERRCNT))
               prdata[15:0] <= {rx_err_cnt, tx_err_cnt};
         end
      end
   end

   // Mode control one; writes outside initialization are dropped silently
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         can_mode_control_one <= CTL1_RESET;
         enable_locked <= 1'b0;
      end
      else if (wr_ctl1)
      begin
         can_mode_control_one[CTL1_CLKSEL] <= pwdata[CTL1_CLKSEL];
         can_mode_control_one[CTL1_LOOPBACK] <= pwdata[CTL1_LOOPBACK];
         can_mode_control_one[CTL1_LISTEN] <= pwdata[CTL1_LISTEN];
         can_mode_control_one[CTL1_WAKEFILT] <= pwdata[CTL1_WAKEFILT];
         // Normal mode takes only the first enable write after reset
         if (special_mode || !enable_locked)
            can_mode_control_one[CTL1_ENABLE] <= pwdata[CTL1_ENABLE];
         if (!special_mode)
            enable_locked <= 1'b1;
      end
   end

   // Mode control zero; a wake clears the sleep request in hardware
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         init_request_bit <= CTL0_RESET[CTL0_INITREQ];
         sleep_request_bit <= CTL0_RESET[CTL0_SLEEPREQ];
         wakeup_enable_bit <= CTL0_RESET[CTL0_WAKEEN];
      end
      else
      begin
         if (wr_ctl0)
         begin
            init_request_bit <= pwdata[CTL0_INITREQ];
            sleep_request_bit <= pwdata[CTL0_SLEEPREQ];
            wakeup_enable_bit <= pwdata[CTL0_WAKEEN];
         end
         if (wif.wake && state == ST_SLEEP)
            sleep_request_bit <= 1'b0;
      end
   end

   // Operating state
   always_comb
   begin
      next_state = state;
      case (state)
         ST_OFF:
            if (enabled)
               next_state = ST_INIT;
         ST_INIT:
            if (!init_request_bit)
               next_state = ST_RUN;
         ST_RUN:
            if (init_request_bit)
               next_state = ST_INIT;
            else if (sleep_request_bit)
               next_state = ST_SLEEP;
         ST_SLEEP:
            if (init_request_bit)
               next_state = ST_INIT;
            else if ((wif.wake && wakeup_enable_bit) || !sleep_request_bit)
               next_state = ST_RUN;
         default:
            next_state = ST_OFF;
      endcase
      if (!enabled)
         next_state = ST_OFF;
   end

   // State and acknowledges follow the next state, so they settle together
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_OFF;
         init_acknowledge_bit <= 1'b0;
         sleep_ack <= 1'b0;
      end
      else
      begin
         state <= next_state;
         init_acknowledge_bit <= init_request_bit
            && (next_state == ST_OFF || next_state == ST_INIT);
         sleep_ack <= (next_state == ST_SLEEP);
      end
   end

   // Wake filter hookup; loopback keeps the pin from waking the node
   assign wif.rx_level = loopback ? BIT_RECESSIVE : rx_sync;
   assign wif.filter_on = can_mode_control_one[CTL1_WAKEFILT];
   assign wif.arm = (state == ST_SLEEP) && wakeup_enable_bit;

   cmc_wake_filter #(
      .MIN_CYC(WAKE_CYCLES)
   ) u_wake (
      .pclk(pclk),
      .presetn(presetn),
      .w(wif)
   );

   // Serial paths to the pin and to the engine's receiver
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_transmit_pin <= BIT_RECESSIVE;
         eng_rx_bit <= BIT_RECESSIVE;
      end
      else
      begin
         eng_rx_bit <= loopback ? eng_tx_bit : rx_sync;
         if (state != ST_RUN || loopback)
            bus_transmit_pin <= BIT_RECESSIVE;
         else if (listen && eng_ack_or_error)
            bus_transmit_pin <= BIT_RECESSIVE;
         else
            bus_transmit_pin <= eng_tx_bit;
      end
   end

   // Mode outputs to the engine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         eng_enable <= 1'b0;
         eng_run <= 1'b0;
         eng_ack_ignore <= 1'b0;
         eng_tx_grant <= 1'b0;
         proto_clk_sel <= 1'b0;
      end
      else
      begin
         eng_enable <= enabled;
         eng_run <= (state == ST_RUN);
         eng_ack_ignore <= loopback;
         eng_tx_grant <= eng_tx_request && state == ST_RUN && !listen;
         proto_clk_sel <= can_mode_control_one[CTL1_CLKSEL];
      end
   end

   // Error counters saturate at both ends and stand still while listening
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_err_cnt <= ERR_RESET;
         rx_err_cnt <= ERR_RESET;
      end
      else if (!listen)
      begin
         if (eng_tx_err_inc && tx_err_cnt != ERR_MAX)
            tx_err_cnt <= tx_err_cnt + 8'h01;
         else if (eng_tx_err_dec && tx_err_cnt != ERR_RESET)
            tx_err_cnt <= tx_err_cnt - 8'h01;
         if (eng_rx_err_inc && rx_err_cnt != ERR_MAX)
            rx_err_cnt <= rx_err_cnt + 8'h01;
         else if (eng_rx_err_dec && rx_err_cnt != ERR_RESET)
            rx_err_cnt <= rx_err_cnt - 8'h01;
      end
   end

   // Events come from the engine the same way in loopback as on the bus
   assign ev_set[EV_TXDONE] = eng_tx_done;
   assign ev_set[EV_RXDONE] = eng_rx_done;
   assign ev_set[EV_WAKE] = wif.wake && state == ST_SLEEP;
   assign ev_clr = rd_status ? prdata[EV_N-1:0] : '0;

   // Sticky status bits; a new event beats the read-clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < EV_N; gi++)
      begin : g_status
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               status[gi] <= EV_RESET[gi];
            else if (ev_set[gi])
               status[gi] <= 1'b1;
            else if (ev_clr[gi])
               status[gi] <= 1'b0;
         end
      end
   endgenerate

   // Mask register and the level interrupt
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask <= EV_RESET;
         irq <= 1'b0;
      end
      else
      begin
         if (wr_mask)
            mask <= pwdata[EV_N-1:0];
         irq <= |(status & mask);
      end
   end

endmodule : cmc_top
`default_nettype wire

// file: cmc_wake_filter.sv
// Wake-up detector: any dominant level, or a dominant pulse of minimum length.
// Assumes rx_level is already synchronised to the clock.
`timescale 1ns/1ps
`default_nettype none
module cmc_wake_filter
#(
   parameter logic [15:0] MIN_CYC = 16'd20
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Controller side
   cmc_wake_if.filt w
);
   import cmc_pkg::*;

   logic [WAKE_CNT_W-1:0] run_len;
   logic dominant;

   assign dominant = (w.rx_level == BIT_DOMINANT);

   // Length of the current dominant run, saturating so it never wraps
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_len <= '0;
      else if (!w.arm || !dominant)
         run_len <= '0;
      else if (run_len != MIN_CYC)
         run_len <= run_len + 16'h0001;
   end

   // One pulse per dominant run: first sample, or once the run is long enough
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         w.wake <= 1'b0;
      else if (w.arm && dominant && !w.filter_on)
         w.wake <= (run_len == '0);
      else if (w.arm && dominant)
         w.wake <= (run_len == MIN_CYC - 16'h0001);
      else
         w.wake <= 1'b0;
   end

endmodule : cmc_wake_filter
`default_nettype wire

// file: cmc_wake_if.sv
// Signals between the mode controller and its wake-up filter.
// Assumes both ends run on the APB clock.
`timescale 1ns/1ps
`default_nettype none
interface cmc_wake_if;
   logic rx_level;
   logic filter_on;
   logic arm;
   logic wake;

   modport filt (input rx_level, input filter_on, input arm, output wake);
   modport ctl (output rx_level, output filter_on, output arm, input wake);
endinterface : cmc_wake_if
`default_nettype wire

// file: tb_top.sv
// Bench: mode, loopback, listen, wake and interrupt scenarios over APB.
// Assumes cmc_top, the bound checker and cmc_bus_node are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cmc_pkg::*;
   // Short wake pulse keeps the run brief
   localparam logic [15:0] WK = 16'h0003;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, bus_receive_pin, bus_transmit_pin, irq;
   logic special_mode = 1'b0, tx_bit = 1'b1, ack_err = 1'b0, tx_req = 1'b0;
   logic [3:0] ev = 4'h0; // tx done, rx done, tx err up, rx err up
   logic en, run, rx_bit, ack_ign, grant, clk_sel;
   int fail_count = 0, total_checks = 0;
   // Clock at 200 MHz
   always #2.5 pclk = ~pclk;
   cmc_top #(.WAKE_CYCLES(WK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
      .bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin),
      .eng_tx_bit(tx_bit), .eng_ack_or_error(ack_err), .eng_tx_request(tx_req),
      .eng_tx_done(ev[0]), .eng_rx_done(ev[1]), .eng_tx_err_inc(ev[2]),
      .eng_tx_err_dec(1'b0), .eng_rx_err_inc(ev[3]), .eng_rx_err_dec(1'b0),
      .eng_enable(en), .eng_run(run), .eng_rx_bit(rx_bit), .eng_ack_ignore(ack_ign),
      .eng_tx_grant(grant), .proto_clk_sel(clk_sel), .irq(irq));
   cmc_bus_node node (.pclk(pclk), .bus_transmit_pin(bus_transmit_pin),
      .bus_receive_pin(bus_receive_pin));
   task automatic end_of_test;
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One APB transfer; held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge, so a following call never raises psel again in this step
      @(posedge pclk);
   endtask : apb
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rchk
   task automatic pulse(input logic [3:0] m);
      ev <= m;
      @(posedge pclk);
      ev <= 4'h0;
      repeat (2) @(posedge pclk);
   endtask : pulse
   // Enter initialisation, load mode control one, run again
   task automatic setm(input logic [7:0] c1);
      apb(1'b1, OFS_CTL0, 32'h1);
      repeat (3) @(posedge pclk);
      rchk(OFS_CTL0, 32'h11, "init ack");
      apb(1'b1, OFS_CTL1, {24'h0, c1});
      apb(1'b1, OFS_CTL0, 32'h0);
      repeat (3) @(posedge pclk);
   endtask : setm
   task automatic s_reset;
      rchk(OFS_CTL1, 32'h0, "ctl1");
      rchk(OFS_CTL0, 32'h11, "ctl0");
      rchk(OFS_STATUS, 32'h0, "status");
      rchk(OFS_MASK, 32'h0, "mask");
      rchk(OFS_ERRCNT, 32'h0, "errcnt");
      rchk(8'h14, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, err});
   endtask : s_reset
   task automatic s_enable;
      apb(1'b1, OFS_CTL1, 32'hc0);
      rchk(OFS_CTL1, 32'hc0, "ctl1 set");
      chk("enable clksel", 32'h3, {30'h0, en, clk_sel});
      apb(1'b1, OFS_CTL1, 32'h40);
      rchk(OFS_CTL1, 32'hc0, "enable locked");
      special_mode <= 1'b1;
      apb(1'b1, OFS_CTL1, 32'h00);
      rchk(OFS_CTL1, 32'h00, "enable special");
      chk("off oscillator", 32'h0, {30'h0, en, clk_sel});
      apb(1'b1, OFS_CTL1, 32'h80);
      special_mode <= 1'b0;
   endtask : s_enable
   task automatic s_irq;
      apb(1'b1, OFS_CTL0, 32'h0);
      apb(1'b1, OFS_CTL1, 32'hff);
      rchk(OFS_CTL1, 32'h80, "ctl1 guarded");
      chk("run", 32'h1, {31'h0, run});
      apb(1'b1, OFS_MASK, 32'h1);
      pulse(4'h3);
      chk("irq", 32'h1, {31'h0, irq});
      rchk(OFS_STATUS, 32'h3, "status");
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      pulse(4'h2);
      chk("irq masked", 32'h0, {31'h0, irq});
      rchk(OFS_STATUS, 32'h2, "status masked");
   endtask : s_irq
   task automatic s_listen;
      setm(8'h90);
      pulse(4'hc);
      tx_req <= 1'b1;
      ack_err <= 1'b1;
      tx_bit <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("grant listen", 32'h0, {31'h0, grant});
      chk("pin listen", 32'h1, {31'h0, bus_transmit_pin});
      rchk(OFS_ERRCNT, 32'h0, "errcnt frozen");
      ack_err <= 1'b0;
      setm(8'h80);
      chk("grant", 32'h1, {31'h0, grant});
      chk("pin normal", 32'h0, {31'h0, bus_transmit_pin});
      pulse(4'hc);
      rchk(OFS_ERRCNT, 32'h0101, "errcnt");
      tx_req <= 1'b0;
      tx_bit <= 1'b1;
   endtask : s_listen
   task automatic s_loop;
      setm(8'ha0);
      tx_bit <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("rx loop low", 32'h0, {31'h0, rx_bit});
      chk("pin loop", 32'h1, {31'h0, bus_transmit_pin});
      chk("ack ignore", 32'h1, {31'h0, ack_ign});
      tx_bit <= 1'b1;
      fork
         node.drive_dominant(5);
         begin
            repeat (4) @(posedge pclk);
            chk("rx loop high", 32'h1, {31'h0, rx_bit});
         end
      join
      pulse(4'h3);
      rchk(OFS_STATUS, 32'h3, "loop events");
   endtask : s_loop
   task automatic s_wake(input logic [7:0] c1, input int n, input logic [31:0] e);
      setm(c1);
      apb(1'b1, OFS_CTL0, 32'h6);
      repeat (3) @(posedge pclk);
      rchk(OFS_CTL0, 32'h0e, "sleeping");
      node.drive_dominant(n);
      repeat (6) @(posedge pclk);
      rchk(OFS_STATUS, e, "wake flag");
      chk("run after wake", {31'h0, e[2]}, {31'h0, run});
   endtask : s_wake
   // Main sequence
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      s_reset();
      s_enable();
      s_irq();
      s_listen();
      s_loop();
      s_wake(8'h80, 1, 32'h4);
      s_wake(8'h84, int'(WK) - 1, 32'h0);
      s_wake(8'h84, int'(WK), 32'h4);
      end_of_test();
   end
   // Watchdog well beyond the expected run
   initial
   begin
      #100us;
      fail_count++;
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
